//--- hdl/crmenc_top.sv
// Operation
// R1: Every response is exactly 32 bits.
// R2: Three chips per symbol, one nibble each.
// R3: Chip levels: quiescent, one step, two steps.
// R4: Nibbles map to fixed three-chip patterns.
// R5: Symbols never start quiet nor stay flat.
// R6: Fields: address, command, high, low, check.
// R7: Command field echoes received command code.
// R8: High byte is word address plus one.
// R9: Low byte is word address plus zero.
// R10: Check covers all 24 message bits.
// R11: Check takes bits serially, MSB first.
// R12: Seed all ones, polynomial x8+x5+x3+x2+x+1.
// R13: Eight zero bits follow before result.
// R14: Check sent last, after low byte.
// R15: Seed loaded before each new calculation.
// R16: Failed command check means no response.
// R17: Answer only own address, never global.
// R18: Unreadable register returns zero data.
// R19: Eight symbols, most significant nibble first.
// R20: Master decodes triplets, rejects unlisted ones.
`timescale 1ns/1ns
`default_nettype none
`include "crmenc_cfg.svh"

module crmenc_top
  import crmenc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] phys_addr_reg,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_phys_addr,
  input wire logic [3:0] cmd_code,
  input wire logic [6:0] reg_word_addr,
  input wire logic cmd_crc_ok,
  output logic cmd_ready,
  output logic [7:0] reg_rd_addr,
  input wire logic [7:0] reg_rd_data,
  input wire logic reg_rd_ok,
  input wire logic line_ready,
  output logic [1:0] chip_level,
  output logic resp_active
);

  // ****************************************************************
  // Symbol table
  // ****************************************************************

  localparam logic [7:0] CHIP_LAST_CNT = 8'(`CRMENC_CHIP_CYC - 1);
  localparam int CHIP_CYC = `CRMENC_CHIP_CYC;

  // R5: no quiet start or flat symbol
  // R4: nibble to chips
  // Each code holds first, second and third chip, two bits each.
  function automatic logic [5:0] sym_code(input logic [3:0] nib);
    logic [5:0] c;
    c = 6'h00;
    unique case (nib)
      4'h0: c = 6'h14;
      4'h1: c = 6'h25;
      4'h2: c = 6'h12;
      4'h3: c = 6'h22;
      4'h4: c = 6'h10;
      4'h5: c = 6'h26;
      4'h6: c = 6'h16;
      4'h7: c = 6'h21;
      4'h8: c = 6'h28;
      4'h9: c = 6'h24;
      4'hA: c = 6'h1A;
      4'hB: c = 6'h29;
      4'hC: c = 6'h18;
      4'hD: c = 6'h20;
      4'hE: c = 6'h11;
      4'hF: c = 6'h19;
    endcase
    return c;
  endfunction

  // R2: chip within symbol
  // Picks the level of chip idx; idx 3 cannot occur and falls back to quiet.
  function automatic logic [1:0] sym_chip(input logic [3:0] nib, input logic [1:0] idx);
    logic [5:0] c;
    logic [1:0] l;
    c = sym_code(nib);
    unique case (idx)
      2'h0: l = c[5:4];
      2'h1: l = c[3:2];
      2'h2: l = c[1:0];
      default: l = `CRMENC_LVL_QUIET;
    endcase
    return l;
  endfunction

  // ****************************************************************
  // State and datapath
  // ****************************************************************

  crmenc_main_t q, d;
  logic accept;
  logic crc_init, crc_shift, crc_bit;
  logic [7:0] crc_val;
  logic [23:0] msg;
  logic [31:0] frame_sh;
  logic [4:0] msg_idx;
  logic push_valid, push_ready;
  logic [3:0] push_data;
  logic pop_valid, pop_ready;
  logic [3:0] pop_data;

  // R6: field order
  assign msg = {q.pa, q.cmd, q.hi, q.lo};
  // R1: 32-bit frame, four fields plus check
  // R14: check sent last
  assign frame_sh = {msg, crc_val} << {q.nib, 2'b00};
  // R11: index of bit fed this cycle, counting down from 23.
  assign msg_idx = 5'(5'h17 - q.cnt[4:0]);

  // R16: bad check never starts a response
  // R17: own address only, global address ignored
  assign accept = cmd_valid && cmd_crc_ok && (cmd_phys_addr == phys_addr_reg)
      && (cmd_phys_addr != `CRMENC_GLOBAL_ADDR);

  // Builder and chip transmitter share one next-state process.
  always_comb begin
    d = q;
    crc_init = 1'b0;
    crc_shift = 1'b0;
    crc_bit = 1'b0;
    push_valid = 1'b0;
    push_data = frame_sh[31:28];
    pop_ready = 1'b0;
    unique case (q.st)
      ST_IDLE: begin
        if (accept) begin
          d.pa = cmd_phys_addr;
          // R7: command echo
          d.cmd = cmd_code;
          d.word = reg_word_addr;
          // R15: seed before each calculation
          crc_init = 1'b1;
          d.st = ST_RD_LO;
        end
      end
      ST_RD_LO: begin
        // R18: unreadable gives zero
        d.lo = reg_rd_ok ? reg_rd_data : 8'h00;
        d.st = ST_RD_HI;
      end
      ST_RD_HI: begin
        d.hi = reg_rd_ok ? reg_rd_data : 8'h00;
        d.cnt = 6'h00;
        d.st = ST_CRC;
      end
      ST_CRC: begin
        crc_shift = 1'b1;
        // R10: all message bits, then R13: eight zeros
        crc_bit = (q.cnt >= `CRMENC_FEED_ZERO) ? 1'b0 : msg[msg_idx];
        d.cnt = 6'(q.cnt + 6'h01);
        if (q.cnt == `CRMENC_LAST_FEED) begin
          d.nib = 3'h0;
          d.st = ST_SEND;
        end
      end
      ST_SEND: begin
        // R19: eight nibbles, most significant first
        push_valid = 1'b1;
        if (push_ready) begin
          d.nib = 3'(q.nib + 3'h1);
          if (q.nib == `CRMENC_LAST_NIB) begin
            d.st = ST_IDLE;
          end
        end
      end
    endcase

    // A stall on the line is taken only between symbols, so a symbol is never cut.
    if (q.busy && q.tmr != 8'h00) begin
      d.tmr = 8'(q.tmr - 8'h01);
    end else if (q.busy && q.chip != `CRMENC_LAST_CHIP) begin
      d.chip = 2'(q.chip + 2'h1);
      d.tmr = CHIP_LAST_CNT;
      // R3: one of three levels
      d.level = sym_chip(q.sym, d.chip);
    end else if (pop_valid && line_ready) begin
      pop_ready = 1'b1;
      d.busy = 1'b1;
      d.sym = pop_data;
      d.chip = 2'h0;
      d.tmr = CHIP_LAST_CNT;
      d.level = sym_chip(pop_data, 2'h0);
    end else begin
      d.busy = 1'b0;
      d.level = `CRMENC_LVL_QUIET;
    end
  end

  // State register.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '{st: ST_IDLE, default: '0};
    end else begin
      q <= d;
    end
  end

  // R8: plus one for high byte; R9: plus zero for low byte
  assign reg_rd_addr = {q.word, (q.st == ST_RD_HI)};
  assign cmd_ready = (q.st == ST_IDLE);
  assign chip_level = q.level;
  assign resp_active = q.busy;

  // ****************************************************************
  // Submodules
  // ****************************************************************

  // R12: seed and polynomial live in the generator.
  crmenc_crc u_crc (
    .clk(clk),
    .sys_rst(sys_rst),
    .init(crc_init),
    .shift_en(crc_shift),
    .bit_in(crc_bit),
    .crc_val(crc_val)
  );

  // The builder is far faster than the line, so it fills this and waits.
  crmenc_buf2 #(
    .W(4)
  ) u_buf (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(pop_valid),
    .out_ready(pop_ready),
    .out_data(pop_data)
  );

  // ****************************************************************
  // Assertions
  // ****************************************************************

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Counts symbols queued in the current frame.
  logic [3:0] sym_cnt_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sym_cnt_q <= 4'h0;
    end else if (q.st == ST_IDLE && accept) begin
      sym_cnt_q <= 4'h0;
    end else if (push_valid && push_ready) begin
      sym_cnt_q <= 4'(sym_cnt_q + 4'h1);
    end
  end

  frame_len_a: assert property ((push_valid && push_ready && q.nib == `CRMENC_LAST_NIB) |=> // R1
      (q.st == ST_IDLE) && (sym_cnt_q == 4'h8))
    else $error("response did not end after eight symbols");

  // Table entry of the symbol on the line, so its chips can be checked as a whole.
  logic [5:0] cur_code;
  assign cur_code = sym_code(q.sym);

  sym_start_a: assert property ((q.busy && q.chip == 2'h0) |-> // R5
      (q.level != `CRMENC_LVL_QUIET) && (cur_code[5:4] != `CRMENC_LVL_QUIET))
    else $error("symbol starts at quiescent level");

  sym_flat_a: assert property (q.busy |-> // R5
      !(cur_code[5:4] == cur_code[3:2] && cur_code[3:2] == cur_code[1:0]))
    else $error("symbol has three equal chips");

  chip_hold_a: assert property ((q.busy && q.tmr == CHIP_LAST_CNT && q.chip != `CRMENC_LAST_CHIP) |-> // R2
      ##CHIP_CYC (q.busy && q.chip == $past(q.chip, CHIP_CYC) + 2'h1))
    else $error("chip did not advance after one chip time");

  echo_a: assert property ((q.st == ST_IDLE && accept) |=> // R7
      (q.cmd == $past(cmd_code)) && (q.pa == $past(phys_addr_reg)))
    else $error("command echo or address not captured");

  seed_a: assert property ((q.st == ST_IDLE && accept) |=> (crc_val == `CRMENC_CRC_SEED)) // R15
    else $error("check register not seeded");

  zero_feed_a: assert property ((q.st == ST_CRC && q.cnt >= `CRMENC_FEED_ZERO) |-> (crc_bit == 1'b0)) // R13
    else $error("nonzero bit fed after the message");

  check_last_a: assert property ((q.st == ST_SEND && q.nib == 3'h6) |-> (push_data == crc_val[7:4])) // R14
    else $error("check field not in the last two symbols");

  discard_a: assert property ((q.st == ST_IDLE && cmd_valid && !cmd_crc_ok) |=> (q.st == ST_IDLE)) // R16
    else $error("response started on failed command check");

  global_a: assert property ((q.st == ST_IDLE && cmd_phys_addr == `CRMENC_GLOBAL_ADDR) |=> (q.st == ST_IDLE)) // R17
    else $error("response started for global address");

  unread_a: assert property ((q.st == ST_RD_LO && !reg_rd_ok) |=> (q.lo == 8'h00) ##1 (q.st == ST_CRC)) // R18
    else $error("unreadable low byte not zero");

  hi_addr_a: assert property ((q.st == ST_RD_HI) |-> (reg_rd_addr == {q.word, 1'b1}) && ($past(reg_rd_addr) == {q.word, 1'b0})) // R8
    else $error("high byte read from wrong address");

  // ****************************************************************
  // Frame layout and chip table checks
  // ****************************************************************

  // Code 3 would ask the driver for a current step that does not exist.
  level_legal_a: assert property (chip_level != 2'h3) // R3
    else $error("chip level outside the three levels");

  quiet_gap_a: assert property (!q.busy |-> (q.level == `CRMENC_LVL_QUIET)) // R3
    else $error("line not quiescent between symbols");

  level_table_a: assert property (q.busy |-> (q.level == sym_chip(q.sym, q.chip))) // R4
    else $error("chip level differs from the symbol table");

  lo_addr_a: assert property ((q.st == ST_RD_LO) |-> (reg_rd_addr == {q.word, 1'b0})) // R9
    else $error("low byte read from wrong address");

  // Twenty-four message bits and eight zeros, one per cycle, then the frame is queued.
  crc_len_a: assert property ((q.st == ST_RD_HI) |=> // R13
      (q.st == ST_CRC && q.cnt == 6'h00) ##32 (q.st == ST_SEND))
    else $error("check feed did not take message plus eight zeros");

  seed_hold_a: assert property ((q.st == ST_RD_LO || q.st == ST_RD_HI) |-> (crc_val == `CRMENC_CRC_SEED)) // R15
    else $error("check register lost its seed before the feed");

  addr_first_a: assert property ((q.st == ST_SEND && q.nib == 3'h0) |-> (push_data == q.pa)) // R19
    else $error("address nibble not sent first");

  cmd_second_a: assert property ((q.st == ST_SEND && q.nib == 3'h1) |-> (push_data == q.cmd)) // R7
    else $error("command echo not in the second symbol");

  hi_third_a: assert property ((q.st == ST_SEND && q.nib == 3'h2) |-> (push_data == q.hi[7:4])) // R8
    else $error("high byte not after the command");

  lo_fifth_a: assert property ((q.st == ST_SEND && q.nib == 3'h4) |-> (push_data == q.lo[7:4])) // R9
    else $error("low byte not after the high byte");

  crc_end_a: assert property ((q.st == ST_SEND && q.nib == 3'h7) |-> (push_data == crc_val[3:0])) // R14
    else $error("check low nibble not sent last");

  resp_sent_c: cover property ((q.st == ST_SEND && q.nib == `CRMENC_LAST_NIB && push_ready) ##[1:1000] !q.busy);
  unread_c: cover property (q.st == ST_RD_HI && !reg_rd_ok);
  stall_c: cover property (pop_valid && !line_ready && !q.busy);
  reject_c: cover property (q.st == ST_IDLE && cmd_valid && !accept);

endmodule

`default_nettype wire

//--- hdl/crmenc_cfg.svh
`ifndef CRMENC_CFG_SVH
`define CRMENC_CFG_SVH

// ****************************************************************
// Response frame layout
// ****************************************************************
`define CRMENC_MSG_BITS 24
`define CRMENC_CRC_BITS 8
`define CRMENC_FRAME_BITS 32
`define CRMENC_NIBBLES 8
`define CRMENC_LAST_NIB 3'h7
`define CRMENC_LAST_FEED 6'h1F
`define CRMENC_FEED_ZERO 6'h18
`define CRMENC_GLOBAL_ADDR 4'h0
`define CRMENC_CMD_READ 4'h0

// ****************************************************************
// Response check sequence
// ****************************************************************
`define CRMENC_CRC_SEED 8'hFF
`define CRMENC_CRC_POLY 8'h2F

// ****************************************************************
// Chip levels and timing
// ****************************************************************
`define CRMENC_LVL_QUIET 2'h0
`define CRMENC_LAST_CHIP 2'h2
`define CRMENC_CLK_NS 10
`define CRMENC_CHIP_TIME_NS 1000
`define CRMENC_CHIP_CYC ((`CRMENC_CHIP_TIME_NS + `CRMENC_CLK_NS - 1) / `CRMENC_CLK_NS)

`endif

//--- hdl/crmenc_pkg.sv
package crmenc_pkg;

  // Sequencer states of the response builder.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_LO,
    ST_RD_HI,
    ST_CRC,
    ST_SEND
  } crmenc_state_t;

  // Whole state of the top module.
  typedef struct packed {
    crmenc_state_t st;
    logic [3:0] pa;
    logic [3:0] cmd;
    logic [6:0] word;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [5:0] cnt;
    logic [2:0] nib;
    logic busy;
    logic [3:0] sym;
    logic [1:0] chip;
    logic [7:0] tmr;
    logic [1:0] level;
  } crmenc_main_t;

  // Whole state of the check sequence generator.
  typedef struct packed {
    logic [7:0] crc;
  } crmenc_crc_t;

endpackage

//--- hdl/crmenc_crc.sv
`timescale 1ns/1ns
`default_nettype none
`include "crmenc_cfg.svh"

module crmenc_crc
  import crmenc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic init,
  input wire logic shift_en,
  input wire logic bit_in,
  output logic [7:0] crc_val
);

  crmenc_crc_t q, d;

  // Serial generator: each bit enters the low end, the old top bit folds the polynomial back in.
  always_comb begin
    d = q;
    if (init) begin
      d.crc = `CRMENC_CRC_SEED;
    end else if (shift_en) begin
      d.crc = {q.crc[6:0], bit_in} ^ (q.crc[7] ? `CRMENC_CRC_POLY : 8'h00);
    end
  end

  // State register.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '{crc: `CRMENC_CRC_SEED};
    end else begin
      q <= d;
    end
  end

  assign crc_val = q.crc;

endmodule

`default_nettype wire

//--- hdl/crmenc_buf2.sv
`timescale 1ns/1ns
`default_nettype none

module crmenc_buf2 #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } crmenc_buf_t;

  crmenc_buf_t q, d;
  logic push, pop;

  // Two entries let the writer keep going for one word while the reader stalls.
  always_comb begin
    d = q;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp = ~q.wp;
    end
    if (pop) begin
      d.rp = ~q.rp;
    end
    d.cnt = 2'(q.cnt + {1'b0, push} - {1'b0, pop});
  end

  // State register.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign in_ready = (q.cnt != 2'h2);
  assign out_valid = (q.cnt != 2'h0);
  assign out_data = q.mem[q.rp];

endmodule

`default_nettype wire

//--- verif/crmenc_master.sv
`timescale 1ns/1ns
`default_nettype none

// ****************
// Receiving master
// ****************
module crmenc_master (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [1:0] chip_level,
  input wire logic resp_active,
  input wire logic stall,
  output logic line_ready,
  output logic nib_valid,
  output logic [3:0] nib,
  output logic sym_err
);
  // Triplets {first, second, third}, two bits a chip, by nibble value.
  localparam logic [5:0] SYM [16] = '{6'h14, 6'h25, 6'h12, 6'h22, 6'h10, 6'h26, 6'h16, 6'h21,
                                      6'h28, 6'h24, 6'h1A, 6'h29, 6'h18, 6'h20, 6'h11, 6'h19};
  logic [8:0] cnt_q;
  logic [3:0] tri_q;
  logic [4:0] hit;

  function automatic logic [4:0] dec(input logic [5:0] s);
    for (int i = 0; i < 16; i++) begin
      if (SYM[i] == s) return {1'b1, 4'(i)};
    end
    return 5'h00;
  endfunction

  // The bench may hold off symbol starts at any cycle.
  assign line_ready = !stall;

  // Decode of the two stored chips and the third one now on the line.
  assign hit = dec({tri_q, chip_level});

  // Chips are sampled mid-chip; a symbol is 300 cycles, so the count wraps onto the next one.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 9'h000;
      tri_q <= 4'h0;
      nib_valid <= 1'b0;
      nib <= 4'h0;
      sym_err <= 1'b0;
    end else begin
      nib_valid <= 1'b0;
      if (!resp_active) begin
        cnt_q <= 9'h000;
        if (chip_level != 2'h0) sym_err <= 1'b1;
      end else begin
        cnt_q <= (cnt_q == 9'h12B) ? 9'h000 : 9'(cnt_q + 9'h001);
        if (cnt_q == 9'h032 || cnt_q == 9'h096) tri_q <= {tri_q[1:0], chip_level};
        if (cnt_q == 9'h0FA) begin
          nib_valid <= 1'b1;
          nib <= hit[3:0];
          if (!hit[4]) sym_err <= 1'b1;
        end
      end
    end
  end
endmodule

`default_nettype wire

//--- verif/tb_crm_response_encoder.sv
`timescale 1ns/1ns
`default_nettype none

// ****************
// Testbench
// ****************
module tb_crm_response_encoder;
  import crmenc_pkg::*;
  logic clk, sys_rst, cmd_valid, cmd_crc_ok, cmd_ready, reg_rd_ok, line_ready;
  logic resp_active, stall, stall_en, nib_valid, sym_err;
  logic [3:0] phys_addr_reg, cmd_phys_addr, cmd_code, nib;
  logic [6:0] reg_word_addr;
  logic [7:0] reg_rd_addr, reg_rd_data;
  logic [1:0] chip_level;
  logic [7:0] mem [256];
  logic [3:0] exp_q [$];
  int err_total, total_checks;

  crmenc_top u_dut (.clk(clk), .sys_rst(sys_rst), .phys_addr_reg(phys_addr_reg), .cmd_valid(cmd_valid),
    .cmd_phys_addr(cmd_phys_addr), .cmd_code(cmd_code), .reg_word_addr(reg_word_addr),
    .cmd_crc_ok(cmd_crc_ok), .cmd_ready(cmd_ready), .reg_rd_addr(reg_rd_addr),
    .reg_rd_data(reg_rd_data), .reg_rd_ok(reg_rd_ok), .line_ready(line_ready),
    .chip_level(chip_level), .resp_active(resp_active));
  crmenc_master u_master (.clk(clk), .sys_rst(sys_rst), .chip_level(chip_level),
    .resp_active(resp_active), .stall(stall), .line_ready(line_ready), .nib_valid(nib_valid),
    .nib(nib), .sym_err(sym_err));

  // The top quarter of the map is unreadable and shows junk, which must not leak out.
  assign reg_rd_ok = reg_rd_addr[7:6] != 2'h3;
  assign reg_rd_data = reg_rd_ok ? mem[reg_rd_addr] : ~reg_rd_addr;

  // Clock of 10 ns.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Report a mismatch at once and count every comparison.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Seed all ones, poly 0x2F, the 24 message bits then eight zeros.
  function automatic logic [7:0] crc_f(input logic [23:0] m);
    logic [7:0] r;
    logic [31:0] f;
    r = 8'hFF;
    f = {m, 8'h00};
    for (int i = 31; i >= 0; i--) r = {r[6:0], f[i]} ^ (r[7] ? 8'h2F : 8'h00);
    return r;
  endfunction

  // Present one command when idle and queue the reply the master should decode.
  task automatic cmd(input logic [3:0] pa, input logic [3:0] cd, input logic [6:0] w, input logic ok);
    logic [7:0] lo, hi;
    logic [31:0] f;
    int n;
    n = 0;
    // Let an edge pass so a new strobe never lands in the step that lowered the last one.
    @(negedge clk);
    while (cmd_ready !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    chk(cmd_ready, 1'b1);
    cmd_valid = 1'b1;
    cmd_phys_addr = pa;
    cmd_code = cd;
    reg_word_addr = w;
    cmd_crc_ok = ok;
    @(negedge clk);
    cmd_valid = 1'b0;
    if (ok && pa == phys_addr_reg && pa != 4'h0) begin
      lo = (w[6:5] == 2'h3) ? 8'h00 : mem[{w, 1'b0}];
      hi = (w[6:5] == 2'h3) ? 8'h00 : mem[{w, 1'b1}];
      f = {pa, cd, hi, lo, 8'h00};
      f[7:0] = crc_f(f[31:8]);
      for (int i = 7; i >= 0; i--) exp_q.push_back(f[i*4+:4]);
    end
  endtask

  // Every decoded nibble must be the next one expected.
  always @(negedge clk) begin
    if (nib_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(32'h1, 32'h0);
      else chk(nib, exp_q.pop_front());
    end
  end

  // Random stalls of the line once enabled.
  always @(negedge clk) stall <= stall_en && ($urandom % 4 == 0);

  // Watchdog well beyond the expected run of about 51000 cycles, inside the run limit.
  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    stop_test();
  end

  // Main sequence.
  initial begin
    int n;
    {sys_rst, cmd_valid, cmd_crc_ok, stall_en} = 4'h8;
    phys_addr_reg = 4'h5;
    {cmd_phys_addr, cmd_code, reg_word_addr} = 15'h0000;
    err_total = 0;
    total_checks = 0;
    void'($urandom(32'h72fb3344));
    // The reference check generator must reproduce a known example before it judges the design.
    chk(crc_f(24'h181186), 8'hB0);
    for (int i = 0; i < 256; i++) mem[i] = 8'($urandom);
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    // Every command code echoed, back to back.
    for (int c = 0; c < 16; c++) cmd(4'h5, 4'(c), 7'($urandom), 1'b1);
    cmd(4'h5, 4'h0, 7'h7F, 1'b1);
    stall_en = 1'b1;
    cmd(4'h5, 4'h3, 7'h60, 1'b1);
    // Bad check, foreign and global address give nothing.
    cmd(4'h5, 4'h0, 7'h01, 1'b0);
    cmd(4'h3, 4'h0, 7'h02, 1'b1);
    cmd(4'h0, 4'h0, 7'h03, 1'b1);
    // A command while busy is dropped.
    cmd(4'h5, 4'h8, 7'h04, 1'b1);
    @(negedge clk);
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    phys_addr_reg = 4'hF;
    cmd(4'hF, 4'($urandom), 7'($urandom), 1'b1);
    phys_addr_reg = 4'h0;
    cmd(4'h0, 4'h0, 7'h05, 1'b1);
    phys_addr_reg = 4'hA;
    cmd(4'hA, 4'hB, 7'($urandom), 1'b1);
    n = 0;
    while ((exp_q.size() != 0 || resp_active !== 1'b0) && n < 30000) begin
      @(negedge clk);
      n++;
    end
    repeat (400) @(negedge clk);
    chk(exp_q.size(), 0);
    chk(resp_active, 1'b0);
    chk(sym_err, 1'b0);
    stop_test();
  end
endmodule

`default_nettype wire
